//--- common/sdbcr_bank_if.sv
// command carrier from decoder to bank trackers
`timescale 1ns/100ps
interface sdbcr_bank_if;
  import sdbcr_pkg::*;
  logic issue;
  sdbcr_cmd_e cmd;
  logic [1:0] bank;
  logic ap;
  logic ckok;
  modport ctrl (output issue, output cmd, output bank, output ap, output ckok);
  modport bank_side (input issue, input cmd, input bank, input ap, input ckok);
endinterface : sdbcr_bank_if

//--- common/sdbcr_cfg.svh
// timing counts and field positions for the bank command checker
`ifndef SDBCR_CFG_SVH
`define SDBCR_CFG_SVH
`define SDBCR_CLK_PERIOD_NS 4
`define SDBCR_ROW_PRECHARGE_TIME_NS 16
`define SDBCR_ROW_PRECHARGE_CYC ((`SDBCR_ROW_PRECHARGE_TIME_NS + `SDBCR_CLK_PERIOD_NS - 1) / `SDBCR_CLK_PERIOD_NS)
`define SDBCR_ACT_TO_COL_TIME_NS 16
`define SDBCR_ACT_TO_COL_CYC ((`SDBCR_ACT_TO_COL_TIME_NS + `SDBCR_CLK_PERIOD_NS - 1) / `SDBCR_CLK_PERIOD_NS)
`define SDBCR_WRITE_RECOVERY_TIME_NS 12
`define SDBCR_WRITE_RECOVERY_CYC ((`SDBCR_WRITE_RECOVERY_TIME_NS + `SDBCR_CLK_PERIOD_NS - 1) / `SDBCR_CLK_PERIOD_NS)
`define SDBCR_SREF_EXIT_TIME_NS 200
`define SDBCR_SREF_EXIT_CYC ((`SDBCR_SREF_EXIT_TIME_NS + `SDBCR_CLK_PERIOD_NS - 1) / `SDBCR_CLK_PERIOD_NS)
`define SDBCR_READ_LATENCY 8
`define SDBCR_WRITE_LATENCY 4
`define SDBCR_BURST_LENGTH 8
`define SDBCR_AP_BIT 8
`define SDBCR_CNT_W 8
`endif

//--- common/sdbcr_pkg.sv
// types for the bank command checker
package sdbcr_pkg;
  typedef enum logic [3:0] {
    SDBCR_CMD_DESEL = 4'h0, SDBCR_CMD_NOP = 4'h1, SDBCR_CMD_ACT = 4'h2, SDBCR_CMD_RD = 4'h3,
    SDBCR_CMD_WR = 4'h4, SDBCR_CMD_PRE = 4'h5, SDBCR_CMD_AREF = 4'h6, SDBCR_CMD_SREF = 4'h7,
    SDBCR_CMD_MRS = 4'h8
  } sdbcr_cmd_e;
  // gray along idle-activating-active-bursting-recovery-precharging
  typedef enum logic [2:0] {
    SDBCR_B_IDLE = 3'h0, SDBCR_B_ACTG = 3'h1, SDBCR_B_ACTIVE = 3'h3, SDBCR_B_BURST = 3'h2,
    SDBCR_B_RECOV = 3'h6, SDBCR_B_PRECH = 3'h7
  } sdbcr_bank_e;
  typedef logic [7:0] sdbcr_cnt_t;
endpackage : sdbcr_pkg

//--- src/sdbcr_bank.sv
// per-bank state tracker with period counters
`timescale 1ns/100ps
`include "sdbcr_cfg.svh"
module sdbcr_bank import sdbcr_pkg::*; #(
  parameter logic [1:0] BANK_ID = 2'h0
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  sdbcr_bank_if.bank_side cmd_in,
  output sdbcr_bank_e state,
  output logic auto_pre,
  output logic pre_period
);
  sdbcr_cnt_t cnt;
  logic hit;
  logic hit_pre;
  localparam sdbcr_cnt_t BURST_CYC = sdbcr_cnt_t'(`SDBCR_BURST_LENGTH / 2);
  localparam sdbcr_cnt_t RD_CYC = sdbcr_cnt_t'(`SDBCR_BURST_LENGTH / 2);
  localparam sdbcr_cnt_t WR_CYC = sdbcr_cnt_t'(`SDBCR_WRITE_LATENCY + `SDBCR_BURST_LENGTH / 2);
  assign hit = cmd_in.issue && cmd_in.ckok && cmd_in.bank == BANK_ID;
  // single-bank precharge during auto precharge is illegal and leaves the bank alone
  assign hit_pre = cmd_in.issue && cmd_in.ckok && cmd_in.cmd == SDBCR_CMD_PRE
                   && (cmd_in.ap || (cmd_in.bank == BANK_ID && !auto_pre));
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state <= SDBCR_B_IDLE;
      cnt <= 8'h00;
      auto_pre <= 1'b0;
      pre_period <= 1'b0;
    end else if (hit_pre && state != SDBCR_B_IDLE) begin
      state <= SDBCR_B_PRECH;
      cnt <= sdbcr_cnt_t'(`SDBCR_ROW_PRECHARGE_CYC);
      auto_pre <= 1'b0;
      pre_period <= 1'b0;
    end else if (hit && cmd_in.cmd == SDBCR_CMD_ACT && state == SDBCR_B_IDLE) begin
      state <= SDBCR_B_ACTG;
      cnt <= sdbcr_cnt_t'(`SDBCR_ACT_TO_COL_CYC);
    end else if (hit && (cmd_in.cmd == SDBCR_CMD_RD || cmd_in.cmd == SDBCR_CMD_WR)
                 && (state == SDBCR_B_ACTIVE || state == SDBCR_B_BURST) && !auto_pre) begin
      state <= SDBCR_B_BURST;
      cnt <= (cmd_in.cmd == SDBCR_CMD_RD) ? RD_CYC : sdbcr_cnt_t'(WR_CYC + sdbcr_cnt_t'(`SDBCR_WRITE_RECOVERY_CYC));
      auto_pre <= cmd_in.ap;
    end else if (cnt > 8'h01) begin
      cnt <= cnt - 8'h01;
    end else begin
      cnt <= 8'h00;
      case (state)
        SDBCR_B_ACTG: state <= SDBCR_B_ACTIVE;
        SDBCR_B_BURST: begin
          if (auto_pre) begin
            state <= SDBCR_B_PRECH;
            cnt <= sdbcr_cnt_t'(`SDBCR_ROW_PRECHARGE_CYC);
            pre_period <= 1'b1;
          end else begin
            state <= SDBCR_B_ACTIVE;
          end
        end
        SDBCR_B_PRECH: begin
          state <= SDBCR_B_IDLE;
          auto_pre <= 1'b0;
          pre_period <= 1'b0;
        end
        default: state <= state;
      endcase
    end
  end
  idle_after_pre_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == SDBCR_B_PRECH && cnt == 8'h01 && !hit_pre |=> state == SDBCR_B_IDLE)
    else $error("bank did not go idle after precharge time");
endmodule : sdbcr_bank

//--- src/sdbcr_bank_cmd_rules.sv
// command decoder and cross-bank legality checker
`timescale 1ns/100ps
`include "sdbcr_cfg.svh"
module sdbcr_bank_cmd_rules import sdbcr_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // command pins
  input wire logic chip_select_n,
  input wire logic row_strobe_n,
  input wire logic col_strobe_n,
  input wire logic write_enable_n,
  input wire logic clock_enable,
  input wire logic bank_select_bit0,
  input wire logic bank_select_bit1,
  input wire logic [11:0] addr,
  // write data mask
  input wire logic [3:0] write_byte_mask,
  input wire logic wdata_valid,
  // decoded command
  output sdbcr_cmd_e cmd_code,
  output logic cmd_valid,
  output logic cmd_legal,
  output logic [1:0] cmd_bank,
  output logic cmd_ap,
  output logic [11:0] mode_opcode,
  output logic term_disable,
  // bank status and write strobes
  output logic [3:0] bank_idle,
  output logic [3:0] byte_store
);
  sdbcr_bank_if bif ();
  sdbcr_bank_e bstate [4];
  logic [3:0] bap;
  logic [3:0] bpre;
  logic cke_prev;
  logic [7:0] xs_cnt;
  logic ckok;
  sdbcr_cmd_e next_cmd;
  logic [1:0] bank;
  logic legal;
  logic all_idle;
  sdbcr_bank_e tgt;
  assign bank = {bank_select_bit1, bank_select_bit0};
  always_comb begin
    next_cmd = SDBCR_CMD_DESEL;
    if (!chip_select_n) begin
      case ({row_strobe_n, col_strobe_n, write_enable_n})
        3'b111: next_cmd = SDBCR_CMD_NOP;
        3'b011: next_cmd = SDBCR_CMD_ACT;
        3'b101: next_cmd = SDBCR_CMD_RD;
        3'b100: next_cmd = SDBCR_CMD_WR;
        3'b010: next_cmd = SDBCR_CMD_PRE;
        3'b001: next_cmd = clock_enable ? SDBCR_CMD_AREF : SDBCR_CMD_SREF;
        3'b000: next_cmd = SDBCR_CMD_MRS;
        default: next_cmd = SDBCR_CMD_NOP;
      endcase
    end
  end
  // clock enable history and self refresh exit
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cke_prev <= 1'b1;
    end else begin
      cke_prev <= clock_enable;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      xs_cnt <= 8'h00;
    end else if (next_cmd == SDBCR_CMD_SREF || !clock_enable) begin
      xs_cnt <= 8'(`SDBCR_SREF_EXIT_CYC);
    end else if (xs_cnt != 8'h00) begin
      xs_cnt <= xs_cnt - 8'h01;
    end
  end
  assign ckok = cke_prev && clock_enable && xs_cnt == 8'h00;
  assign bif.issue = next_cmd != SDBCR_CMD_DESEL && next_cmd != SDBCR_CMD_NOP;
  assign bif.cmd = next_cmd;
  assign bif.bank = bank;
  assign bif.ap = addr[`SDBCR_AP_BIT];
  assign bif.ckok = ckok;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_bank
      sdbcr_bank #(.BANK_ID(2'(gi))) u_bank (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .cmd_in(bif.bank_side),
        .state(bstate[gi]),
        .auto_pre(bap[gi]),
        .pre_period(bpre[gi])
      );
    end
  endgenerate
  assign all_idle = bstate[0] == SDBCR_B_IDLE && bstate[1] == SDBCR_B_IDLE
                    && bstate[2] == SDBCR_B_IDLE && bstate[3] == SDBCR_B_IDLE;
  assign tgt = bstate[bank];
  // other banks never block bank m's own permitted command
  always_comb begin
    legal = 1'b0;
    case (next_cmd)
      SDBCR_CMD_DESEL, SDBCR_CMD_NOP: legal = 1'b1;
      SDBCR_CMD_ACT: legal = ckok && tgt == SDBCR_B_IDLE;
      SDBCR_CMD_RD, SDBCR_CMD_WR: legal = ckok && !bap[bank]
        && (tgt == SDBCR_B_ACTIVE || tgt == SDBCR_B_BURST);
      SDBCR_CMD_PRE: legal = ckok && (addr[`SDBCR_AP_BIT] || !bap[bank]);
      SDBCR_CMD_AREF, SDBCR_CMD_MRS: legal = ckok && all_idle;
      SDBCR_CMD_SREF: legal = cke_prev && all_idle;
      default: legal = 1'b0;
    endcase
  end
  // decoded outputs
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cmd_code <= SDBCR_CMD_DESEL;
      cmd_valid <= 1'b0;
      cmd_legal <= 1'b1;
      cmd_bank <= 2'h0;
      cmd_ap <= 1'b0;
      mode_opcode <= 12'h000;
    end else begin
      cmd_code <= next_cmd;
      cmd_valid <= bif.issue;
      cmd_legal <= legal;
      cmd_bank <= bank;
      cmd_ap <= addr[`SDBCR_AP_BIT];
      if (next_cmd == SDBCR_CMD_MRS) begin
        mode_opcode <= addr;
      end
    end
  end
  // terminator disable snoop ignores chip select and address
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      term_disable <= 1'b0;
    end else begin
      term_disable <= row_strobe_n && !col_strobe_n && write_enable_n;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bank_idle <= 4'hf;
    end else begin
      for (int i = 0; i < 4; i++) begin
        bank_idle[i] <= bstate[i] == SDBCR_B_IDLE;
      end
    end
  end
  // byte store strobes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      byte_store <= 4'h0;
    end else begin
      byte_store <= wdata_valid ? ~write_byte_mask : 4'h0;
    end
  end
  sequence s_deselect;
    chip_select_n && !(row_strobe_n && !col_strobe_n && write_enable_n);
  endsequence
  deselect_no_cmd_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_deselect |=> !cmd_valid && cmd_code == SDBCR_CMD_DESEL)
    else $error("deselect produced a command");
  decode_read_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !chip_select_n && row_strobe_n && !col_strobe_n && write_enable_n |=> cmd_code == SDBCR_CMD_RD && cmd_valid)
    else $error("read not decoded");
  decode_refresh_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !chip_select_n && !row_strobe_n && !col_strobe_n && write_enable_n
    |=> cmd_code == ($past(clock_enable) ? SDBCR_CMD_AREF : SDBCR_CMD_SREF))
    else $error("refresh decode wrong");
  snoop_ignores_cs_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    chip_select_n && row_strobe_n && !col_strobe_n && write_enable_n |=> term_disable)
    else $error("terminator disable missed");
  mask_store_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    wdata_valid |=> byte_store == ~$past(write_byte_mask))
    else $error("mask not applied to byte store");
  cke_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !clock_enable ##1 (!chip_select_n && !row_strobe_n && col_strobe_n && write_enable_n) |=> !cmd_legal)
    else $error("command allowed right after clock enable low");
  refresh_idle_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    next_cmd == SDBCR_CMD_AREF && !all_idle |=> !cmd_legal)
    else $error("refresh allowed with bank busy");
  act_to_active_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(bstate[0] == SDBCR_B_ACTG) |-> (bstate[0] == SDBCR_B_ACTG)[*4] ##1 (bstate[0] != SDBCR_B_ACTG))
    else $error("activation period length wrong");
endmodule : sdbcr_bank_cmd_rules

//--- tb/sdbcr_ctrl_model.sv
// controller side model turning command requests into pin levels
`timescale 1ns/100ps
module sdbcr_ctrl_model import sdbcr_pkg::*; (
  // request from the bench
  input wire sdbcr_cmd_e req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [11:0] req_addr,
  input wire logic req_desel,
  // command pins
  output logic chip_select_n,
  output logic row_strobe_n,
  output logic col_strobe_n,
  output logic write_enable_n,
  output logic clock_enable,
  output logic bank_select_bit0,
  output logic bank_select_bit1,
  output logic [11:0] addr
);
  logic [2:0] strobes;
  always_comb begin
    case (req_cmd)
      SDBCR_CMD_ACT: strobes = 3'h3;
      SDBCR_CMD_RD: strobes = 3'h5;
      SDBCR_CMD_WR: strobes = 3'h4;
      SDBCR_CMD_PRE: strobes = 3'h2;
      SDBCR_CMD_AREF, SDBCR_CMD_SREF: strobes = 3'h1;
      SDBCR_CMD_MRS: strobes = 3'h0;
      default: strobes = 3'h7;
    endcase
  end
  assign chip_select_n = req_desel | (req_cmd == SDBCR_CMD_DESEL);
  assign {row_strobe_n, col_strobe_n, write_enable_n} = strobes;
  assign clock_enable = (req_cmd != SDBCR_CMD_SREF);
  assign {bank_select_bit1, bank_select_bit0} = req_bank;
  assign addr = req_addr;
endmodule : sdbcr_ctrl_model

//--- tb/tb_sdbcr_bank_cmd_rules.sv
// self-checking bench for the bank command decoder and legality logic
`timescale 1ns/100ps
module tb_sdbcr_bank_cmd_rules import sdbcr_pkg::*; ;
  logic sys_clk, reset_n, chip_select_n, row_strobe_n, col_strobe_n, write_enable_n, clock_enable;
  logic bank_select_bit0, bank_select_bit1, wdata_valid, cmd_valid, cmd_legal, cmd_ap, term_disable, req_desel;
  logic [11:0] addr, mode_opcode, req_addr;
  logic [3:0] write_byte_mask, bank_idle, byte_store;
  logic [1:0] cmd_bank, req_bank;
  sdbcr_cmd_e cmd_code, req_cmd;
  int errors = 0;
  int n_tests = 0;
  sdbcr_ctrl_model i_ctrl (.req_cmd, .req_bank, .req_addr, .req_desel, .chip_select_n, .row_strobe_n,
    .col_strobe_n, .write_enable_n, .clock_enable, .bank_select_bit0, .bank_select_bit1, .addr);
  sdbcr_bank_cmd_rules i_dut (.sys_clk, .reset_n, .chip_select_n, .row_strobe_n, .col_strobe_n,
    .write_enable_n, .clock_enable, .bank_select_bit0, .bank_select_bit1, .addr, .write_byte_mask,
    .wdata_valid, .cmd_code, .cmd_valid, .cmd_legal, .cmd_bank, .cmd_ap, .mode_opcode, .term_disable,
    .bank_idle, .byte_store);
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic issue(input sdbcr_cmd_e c, input logic [1:0] b, input logic [11:0] a, input logic d = 1'b0);
    @(posedge sys_clk);
    #1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_desel = d;
    @(posedge sys_clk);
    #1;
    req_cmd = SDBCR_CMD_NOP;
    req_desel = 1'b0;
  endtask : issue
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : idle
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  task automatic t_desel();
    chk(cmd_code, SDBCR_CMD_DESEL);
    chk(bank_idle, 4'hf);
    issue(SDBCR_CMD_ACT, 2'h0, 12'h0000, 1'b1);
    chk(cmd_valid, 1'b0);
    chk(bank_idle, 4'hf);
    issue(SDBCR_CMD_RD, 2'h1, 12'h0fff, 1'b1);
    chk(term_disable, 1'b1);
    chk(cmd_code, SDBCR_CMD_DESEL);
    issue(SDBCR_CMD_RD, 2'h0, 12'h0fff);
    chk(term_disable, 1'b1);
    chk(cmd_legal, 1'b0);
    $display("test deselect done");
  endtask : t_desel
  task automatic t_cross();
    issue(SDBCR_CMD_ACT, 2'h0, 12'h0123);
    chk(cmd_code, SDBCR_CMD_ACT);
    chk(cmd_legal, 1'b1);
    chk(cmd_bank, 2'h0);
    chk(term_disable, 1'b0);
    issue(SDBCR_CMD_RD, 2'h0, 12'h0000);
    chk(cmd_legal, 1'b0);
    chk(bank_idle, 4'he);
    idle(4);
    issue(SDBCR_CMD_RD, 2'h0, 12'h0000);
    chk(cmd_legal, 1'b1);
    chk(cmd_ap, 1'b0);
    issue(SDBCR_CMD_ACT, 2'h1, 12'h0000);
    chk(cmd_legal, 1'b1);
    chk(cmd_bank, 2'h1);
    issue(SDBCR_CMD_WR, 2'h1, 12'h0000);
    chk(cmd_legal, 1'b0);
    issue(SDBCR_CMD_AREF, 2'h0, 12'h0000);
    chk(cmd_legal, 1'b0);
    @(posedge sys_clk);
    #1;
    wdata_valid = 1'b1;
    write_byte_mask = 4'h5;
    @(posedge sys_clk);
    #1;
    wdata_valid = 1'b0;
    chk(byte_store, 4'ha);
    issue(SDBCR_CMD_PRE, 2'h2, 12'h0100);
    chk(cmd_code, SDBCR_CMD_PRE);
    chk(cmd_legal, 1'b1);
    idle(8);
    chk(bank_idle, 4'hf);
    $display("test cross bank done");
  endtask : t_cross
  task automatic t_autopre();
    issue(SDBCR_CMD_ACT, 2'h2, 12'h0000);
    idle(4);
    issue(SDBCR_CMD_RD, 2'h2, 12'h0100);
    chk(cmd_ap, 1'b1);
    chk(cmd_legal, 1'b1);
    issue(SDBCR_CMD_RD, 2'h2, 12'h0000);
    chk(cmd_legal, 1'b0);
    idle(1);
    issue(SDBCR_CMD_ACT, 2'h3, 12'h0000);
    chk(cmd_legal, 1'b1);
    idle(20);
    chk(bank_idle, 4'h7);
    issue(SDBCR_CMD_WR, 2'h3, 12'h0100);
    chk(cmd_code, SDBCR_CMD_WR);
    chk(cmd_legal, 1'b1);
    idle(20);
    chk(bank_idle, 4'hf);
    $display("test auto precharge done");
  endtask : t_autopre
  task automatic t_decode();
    issue(SDBCR_CMD_MRS, 2'h0, 12'h00a5);
    chk(cmd_code, SDBCR_CMD_MRS);
    chk(mode_opcode, 12'h00a5);
    issue(SDBCR_CMD_NOP, 2'h0, 12'h0000);
    chk(cmd_code, SDBCR_CMD_NOP);
    chk(cmd_valid, 1'b0);
    issue(SDBCR_CMD_AREF, 2'h0, 12'h0000);
    chk(cmd_code, SDBCR_CMD_AREF);
    chk(cmd_valid, 1'b1);
    $display("test decode done");
  endtask : t_decode
  task automatic t_sref();
    idle(20);
    issue(SDBCR_CMD_SREF, 2'h0, 12'h0000);
    chk(cmd_code, SDBCR_CMD_SREF);
    chk(cmd_legal, 1'b1);
    issue(SDBCR_CMD_ACT, 2'h0, 12'h0000);
    chk(cmd_legal, 1'b0);
    idle(60);
    issue(SDBCR_CMD_ACT, 2'h0, 12'h0000);
    chk(cmd_legal, 1'b1);
    $display("test self refresh done");
  endtask : t_sref
  initial begin
    #8000;
    errors++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    req_cmd = SDBCR_CMD_NOP;
    req_bank = 2'h0;
    req_addr = 12'h0000;
    req_desel = 1'b0;
    wdata_valid = 1'b0;
    write_byte_mask = 4'h0;
    repeat (8) @(posedge sys_clk);
    #1;
    reset_n = 1'b1;
    t_desel();
    t_cross();
    t_autopre();
    t_decode();
    t_sref();
    end_of_test();
  end
endmodule : tb_sdbcr_bank_cmd_rules
